// *** hw/dtmf_ctrl_status.v ***
// What this block does
// [RQ1] timed mode: burst then equal pause
// [RQ2] tx ready set after pause, interrupt
// [RQ3] progress plus timed doubles burst, pause
// [RQ4] ready 100 ms after write, 200 doubled
// [RQ5] untimed mode: tone while output enabled
// [RQ6] diagnostic bit drives inverted steering out
// [RQ7] host selects tone mode before diagnostic
// [RQ8] single bit picks one or two tones
// [RQ9] group bit picks row or column
// [RQ10] status bit0 follows bits 1,2; read clears
// [RQ11] tx ready: set pause end, read clears
// [RQ12] rx full set on valid code, read clears
// [RQ13] steering flag set when detect drops, cleared when it rises, not read-cleared
// [RQ14] host runs software reset sequence at start
// [RQ15] host services tx and rx per status
// [RQ16] one address, redirect sends next write
// [RQ17] rx data read-only, tx data write-only
// [RQ18] interrupt pin low on events if enabled; with progress bit set the pin follows the progress tone instead
// [RQ19] control a bit0 enables tone output
// [RQ20] chip select low gates accesses
`include "dtmf_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module dtmf_ctrl_status #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        cs_n,
  input  wire        reg_select_line,
  input  wire        rd_wr,
  input  wire        bus_strobe,
  input  wire [3:0]  data_in,
  output reg  [3:0]  data_out,
  output reg         data_oe,
  input  wire        rx_valid,
  input  wire [3:0]  rx_code,
  input  wire        steer_delayed,
  input  wire        progress_tone,
  output reg         tone_out_en,
  output reg         tone_active,
  output reg  [3:0]  tx_code,
  output reg         single_tone,
  output reg         column_group,
  output reg         int_progress_pin_o,
  output reg         int_progress_pin_oe
);
  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_BURST = 2'd1;
  localparam [1:0] S_PAUSE = 2'd2;
  localparam [15:0] PHASE_TICKS = `PHASE_TICKS;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0]  ctrl_a_reg;
  reg [3:0]  ctrl_b_reg;
  reg        redirect_reg;
  reg [3:0]  rx_data_reg;
  reg        tx_ready_reg;
  reg        rx_full_reg;
  reg        steer_reg;
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [15:0] phase_reg;
  reg        strobe_d_reg;
  reg        rx_valid_d_reg;
  reg        steer_d_reg;

  wire       strobe_lvl;
  wire       rx_valid_lvl;
  wire       steer_lvl;
  wire       progress_lvl;
  wire       tick;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  pin_sync u_sync_strobe (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (bus_strobe),
    .level (strobe_lvl)
  );
  pin_sync u_sync_rxv (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (rx_valid),
    .level (rx_valid_lvl)
  );
  pin_sync u_sync_steer (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (steer_delayed),
    .level (steer_lvl)
  );
  pin_sync u_sync_prog (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (progress_tone),
    .level (progress_lvl)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire strobe_rise = strobe_lvl & ~strobe_d_reg;
  wire acc         = strobe_rise & ~cs_n; // RQ20
  wire wr_ctrl     = acc & reg_select_line & ~rd_wr;
  wire rd_status   = acc & reg_select_line & rd_wr;
  wire wr_tx       = acc & ~reg_select_line & ~rd_wr;
  wire rd_rx       = acc & ~reg_select_line & rd_wr;
  wire rx_event    = rx_valid_lvl & ~rx_valid_d_reg;
  wire untimed     = ctrl_b_reg[`CRB_UNTIMED_BIT];
  wire doubled     = ctrl_a_reg[`CRA_PROGRESS_BIT];
  wire [15:0] phase_len = doubled ? {PHASE_TICKS[14:0], 1'b0}
                                  : PHASE_TICKS; // RQ3
  wire phase_end   = tick & (phase_reg == phase_len - 16'd1);
  wire pause_done  = (state_reg == S_PAUSE) & phase_end;
  wire irq_flag    = tx_ready_reg | rx_full_reg; // RQ10

  // ----------------------------------------------------------------
  // millisecond tick, restarted on each transmit write
  // ----------------------------------------------------------------
  tick_divider #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .mclk  (mclk),
    .rst   (rst),
    .clear (wr_tx),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobe_d_reg   <= 1'b0;
      rx_valid_d_reg <= 1'b0;
      steer_d_reg    <= 1'b0;
    end else begin
      strobe_d_reg   <= strobe_lvl;
      rx_valid_d_reg <= rx_valid_lvl;
      steer_d_reg    <= steer_lvl;
    end
  end

  // ----------------------------------------------------------------
  // control registers on a shared address
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg   <= `CTRL_RESET;
      ctrl_b_reg   <= `CTRL_RESET;
      redirect_reg <= 1'b0;
    end else if (wr_ctrl) begin
      if (redirect_reg) begin
        ctrl_b_reg   <= data_in; // RQ16
        redirect_reg <= 1'b0;
      end else begin
        ctrl_a_reg   <= data_in;
        redirect_reg <= data_in[`CRA_REDIRECT_BIT]; // RQ16
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit data and receive data
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_code     <= 4'h0;
      rx_data_reg <= 4'h0;
    end else begin
      if (wr_tx)
        tx_code <= data_in; // RQ17
      if (rx_event)
        rx_data_reg <= rx_code; // RQ17
    end
  end

  // ----------------------------------------------------------------
  // burst / pause sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:  if (wr_tx && !untimed) state_next = S_BURST; // RQ1
      S_BURST: if (phase_end) state_next = S_PAUSE; // RQ1
      S_PAUSE: if (phase_end) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
    if (untimed)
      state_next = S_IDLE; // RQ5
    else if (wr_tx)
      state_next = S_BURST;
  end

  // phase counter in ticks, restarted per phase
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      phase_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      if (wr_tx || phase_end || untimed)
        phase_reg <= 16'h0;
      else if (tick && state_reg != S_IDLE)
        phase_reg <= phase_reg + 16'd1; // RQ4
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over read clear
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ready_reg <= 1'b0;
      rx_full_reg  <= 1'b0;
      steer_reg    <= 1'b0;
    end else begin
      if (untimed)
        tx_ready_reg <= 1'b0; // RQ11
      else if (pause_done)
        tx_ready_reg <= 1'b1; // RQ2
      else if (rd_status)
        tx_ready_reg <= 1'b0; // RQ11
      if (rx_event)
        rx_full_reg <= 1'b1; // RQ12
      else if (rd_status)
        rx_full_reg <= 1'b0; // RQ12
      if (steer_lvl & ~steer_d_reg)
        steer_reg <= 1'b0; // RQ13
      else if (~steer_lvl & steer_d_reg)
        steer_reg <= 1'b1; // RQ13
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out <= `STATUS_RESET;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= ~cs_n & rd_wr;
      if (rd_status)
        data_out <= {steer_reg, rx_full_reg, tx_ready_reg, irq_flag};
      else if (rd_rx)
        data_out <= rx_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // tone generator controls
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tone_out_en  <= 1'b0;
      tone_active  <= 1'b0;
      single_tone  <= 1'b0;
      column_group <= 1'b0;
    end else begin
      tone_out_en  <= ctrl_a_reg[`CRA_TONE_OUT_BIT]; // RQ19
      tone_active  <= ctrl_a_reg[`CRA_TONE_OUT_BIT] &
                      (untimed | (state_next == S_BURST)); // RQ5
      single_tone  <= ctrl_b_reg[`CRB_SINGLE_BIT]; // RQ8
      column_group <= ctrl_b_reg[`CRB_COLUMN_BIT]; // RQ9
    end
  end

  // ----------------------------------------------------------------
  // open drain interrupt / progress pin
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_progress_pin_o  <= 1'b0;
      int_progress_pin_oe <= 1'b0;
    end else begin
      int_progress_pin_o <= 1'b0;
      if (ctrl_b_reg[`CRB_DIAG_BIT])
        int_progress_pin_oe <= steer_lvl; // RQ6
      else if (!ctrl_a_reg[`CRA_IRQ_EN_BIT])
        int_progress_pin_oe <= 1'b0;
      else if (doubled)
        int_progress_pin_oe <= ~progress_lvl;
      else
        int_progress_pin_oe <= irq_flag; // RQ18
    end
  end
endmodule
`default_nettype wire

// *** hw/dtmf_defs.vh ***
`ifndef DTMF_DEFS_VH
`define DTMF_DEFS_VH
// ----------------------------------------------------------------
// control register a fields
// ----------------------------------------------------------------
`define CRA_TONE_OUT_BIT   0
`define CRA_PROGRESS_BIT   1
`define CRA_IRQ_EN_BIT     2
`define CRA_REDIRECT_BIT   3
// ----------------------------------------------------------------
// control register b fields
// ----------------------------------------------------------------
`define CRB_UNTIMED_BIT    0
`define CRB_DIAG_BIT       1
`define CRB_SINGLE_BIT     2
`define CRB_COLUMN_BIT     3
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_IRQ_BIT         0
`define ST_TX_READY_BIT    1
`define ST_RX_FULL_BIT     2
`define ST_STEER_BIT       3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET         4'h0
`define STATUS_RESET       4'h0
// ----------------------------------------------------------------
// timing: phase is 50 ms, tx ready after burst+pause = 100 ms
// ----------------------------------------------------------------
`define CLK_HZ             40000000
`define TICK_US            1000
`define TICK_CYCLES        (`CLK_HZ / 1000000 * `TICK_US)
`define PHASE_MS           50
`define PHASE_TICKS        (`PHASE_MS * 1000 / `TICK_US)
`endif

// *** hw/tick_divider.v ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// one-cycle enable pulse every period cycles
// ----------------------------------------------------------------
module tick_divider #(
  parameter [31:0] PERIOD = 32'd40000
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        clear,
  output reg         tick
);
  reg [31:0] count_reg;

  // free counter, restarted by clear
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else if (clear) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else if (count_reg == PERIOD - 32'd1) begin
      count_reg <= 32'h0;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'd1;
      tick      <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** hw/pin_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// three flop input filter
// ----------------------------------------------------------------
module pin_sync (
  input  wire        mclk,
  input  wire        rst,
  input  wire        pin,
  output reg         level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // change accepted once second and third agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level  <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// *** verification/ctrl_status_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ctrl_status_asserts (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       reg_select_line,
  input wire logic       rd_wr,
  input wire logic       bus_strobe,
  input wire logic [3:0] data_in,
  input wire logic [3:0] data_out,
  input wire logic       data_oe,
  input wire logic       tone_out_en,
  input wire logic       tone_active,
  input wire logic [3:0] tx_code,
  input wire logic       single_tone,
  input wire logic       column_group,
  input wire logic       int_progress_pin_o
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // access steps
  // ------------------------------------------------------------
  sequence tx_wr_s;
    $rose(bus_strobe) && !cs_n && !reg_select_line && !rd_wr
      ##1 ($stable(data_in) && !cs_n)[*7];
  endsequence
  tx_write_a: assert property (tx_wr_s |-> tx_code == data_in)
    else $error("tx code not taken");
  ctrl_write_a: assert property ($changed(tone_out_en) |->
    !$past(cs_n) && $past(reg_select_line) && !$past(rd_wr))
    else $error("tone enable moved without control write");
  gen_config_a: assert property ($changed({single_tone, column_group})
    |-> !$past(cs_n) && $past(reg_select_line) && !$past(rd_wr))
    else $error("tone config moved without control write");
  tx_gate_a: assert property ($changed(tx_code) |->
    !$past(cs_n) && !$past(reg_select_line) && !$past(rd_wr))
    else $error("tx code moved without data write");
  read_path_a: assert property ($changed(data_out) |->
    !$past(cs_n) && $past(rd_wr))
    else $error("read data moved without read");
  oe_follow_a: assert property (data_oe == (!$past(cs_n) && $past(rd_wr)))
    else $error("data enable wrong");
  tone_gate_a: assert property (tone_active |-> tone_out_en)
    else $error("tone without output enable");
  pin_low_a: assert property (int_progress_pin_o == 1'b0)
    else $error("open drain pin drives high");
endmodule
bind dtmf_ctrl_status ctrl_status_asserts i_chk (
  .mclk(mclk), .rst(rst), .cs_n(cs_n), .reg_select_line(reg_select_line),
  .rd_wr(rd_wr), .bus_strobe(bus_strobe), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .tone_out_en(tone_out_en),
  .tone_active(tone_active), .tx_code(tx_code), .single_tone(single_tone),
  .column_group(column_group), .int_progress_pin_o(int_progress_pin_o)
);
`default_nettype wire

// *** verification/tone_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tone_rx_model (
  input  wire logic       mclk,
  input  wire logic       tone_on,
  input  wire logic [3:0] code,
  output var  logic       rx_valid,
  output var  logic [3:0] rx_code,
  output var  logic       steer_delayed,
  output var  logic       progress_tone
);
  logic [4:0] cnt;
  logic [3:0] g;
  initial begin
    rx_valid = 1'b0;
    rx_code = 4'h0;
    steer_delayed = 1'b0;
    progress_tone = 1'b0;
    cnt = 5'h00;
    g = 4'h0;
  end
  // ------------------------------------------------------------
  // receiver: code first, valid and steering after a guard count
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cnt <= cnt + 5'h01;
    progress_tone <= cnt[4];
    if (tone_on) begin
      rx_code <= code;
      if (g != 4'hF) g <= g + 4'h1;
      rx_valid <= (g == 4'hF);
      steer_delayed <= (g == 4'hF);
    end else begin
      g <= 4'h0;
      rx_valid <= 1'b0;
      steer_delayed <= 1'b0;
      rx_code <= ~rx_code; // code flips to its inverse every cycle once released
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       mclk = 0, rst = 1, cs_n = 1, reg_select_line = 0;
  logic       rd_wr = 0, bus_strobe = 0, tone_on = 0;
  logic [3:0] data_in = 4'h0, code = 4'h0, rx_code, data_out, tx_code;
  logic       rx_valid, steer_delayed, progress_tone, data_oe;
  logic       tone_out_en, tone_active, single_tone, column_group;
  logic       pin_o, pin_oe;
  int         num_errors = 0, n_tests = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  // short tick keeps the run small: 50 ticks per phase, 40 cycles a tick
  dtmf_ctrl_status #(.TICK_CYCLES(40)) i_dut (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .reg_select_line(reg_select_line),
    .rd_wr(rd_wr), .bus_strobe(bus_strobe), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rx_valid(rx_valid),
    .rx_code(rx_code), .steer_delayed(steer_delayed),
    .progress_tone(progress_tone), .tone_out_en(tone_out_en),
    .tone_active(tone_active), .tx_code(tx_code),
    .single_tone(single_tone), .column_group(column_group),
    .int_progress_pin_o(pin_o), .int_progress_pin_oe(pin_oe)
  );
  tone_rx_model i_rx (
    .mclk(mclk), .tone_on(tone_on), .code(code), .rx_valid(rx_valid),
    .rx_code(rx_code), .steer_delayed(steer_delayed),
    .progress_tone(progress_tone)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [3:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, got);
    end
  endtask
  // one strobed access, everything held until strobe is long gone
  task automatic acc(input logic rs, rw, input logic [3:0] d);
    @(posedge mclk);
    cs_n <= 1'b0;
    reg_select_line <= rs;
    rd_wr <= rw;
    data_in <= d;
    bus_strobe <= 1'b1;
    repeat (8) @(posedge mclk);
    bus_strobe <= 1'b0;
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    #1;
  endtask
  task automatic rd(input logic rs, input logic [3:0] exp, input string w);
    acc(rs, 1'b1, 4'h0);
    chk(w, exp, data_out);
  endtask
  task automatic tone(input logic on, input int n);
    @(posedge mclk);
    code <= 4'h7;
    tone_on <= on;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(1'b1, 4'h0, "status");
    chk("data oe", 4'h1, {3'h0, data_oe});
    acc(1'b1, 1'b0, 4'h0);
    acc(1'b1, 1'b0, 4'h0);
    acc(1'b1, 1'b0, 4'h8);
    acc(1'b1, 1'b0, 4'h0);
    rd(1'b1, 4'h0, "status");
    chk("outs", 4'h0, {tone_out_en, single_tone, column_group, pin_oe});
    $display("test init done");
    acc(1'b1, 1'b0, 4'h9);
    acc(1'b1, 1'b0, 4'hC);
    chk("cfg", 4'h7, {1'b0, tone_out_en, single_tone, column_group});
    acc(1'b1, 1'b0, 4'h4);
    chk("cfg", 4'h3, {1'b0, tone_out_en, single_tone, column_group});
    $display("test redirect done");
    tone(1'b1, 40);
    chk("pin", 4'h1, {3'h0, pin_oe});
    rd(1'b1, 4'h5, "status");
    rd(1'b0, 4'h7, "rx data");
    rd(1'b1, 4'h0, "status");
    chk("pin", 4'h0, {3'h0, pin_oe});
    tone(1'b0, 20);
    rd(1'b1, 4'h8, "status");
    rd(1'b1, 4'h8, "status");
    $display("test receive done");
    acc(1'b1, 1'b0, 4'h8);
    acc(1'b1, 1'b0, 4'h2);
    chk("cfg", 4'h0, {2'h0, single_tone, column_group});
    tone(1'b1, 40);
    chk("diag pin", 4'h1, {3'h0, pin_oe});
    tone(1'b0, 20);
    chk("diag pin", 4'h0, {3'h0, pin_oe});
    $display("test diag done");
    acc(1'b1, 1'b0, 4'hD);
    acc(1'b1, 1'b0, 4'h1);
    rd(1'b1, 4'hD, "status");
    acc(1'b0, 1'b0, 4'h6);
    chk("tx code", 4'h6, tx_code);
    chk("tone", 4'h1, {3'h0, tone_active});
    rd(1'b1, 4'h8, "status");
    $display("test untimed done");
    acc(1'b1, 1'b0, 4'hD);
    acc(1'b1, 1'b0, 4'h0);
    acc(1'b0, 1'b0, 4'h3);
    repeat (1920) @(posedge mclk);
    #1;
    chk("burst", 4'h1, {3'h0, tone_active});
    repeat (160) @(posedge mclk);
    #1;
    chk("pause", 4'h0, {3'h0, tone_active});
    repeat (1800) @(posedge mclk);
    rd(1'b1, 4'h8, "early ready");
    repeat (200) @(posedge mclk);
    #1;
    chk("ready pin", 4'h1, {3'h0, pin_oe});
    rd(1'b1, 4'hB, "ready");
    chk("ready pin", 4'h0, {pin_o, 2'h0, pin_oe});
    $display("test timed done");
    acc(1'b1, 1'b0, 4'hF);
    acc(1'b1, 1'b0, 4'h0);
    acc(1'b0, 1'b0, 4'h5);
    repeat (3900) @(posedge mclk);
    rd(1'b1, 4'h8, "doubled early");
    repeat (4300) @(posedge mclk);
    rd(1'b1, 4'hB, "doubled ready");
    $display("test doubled done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
